// ---- design/transceiver_pin_function_mux.sv ----
// module: digital pin function mux with APB registers, straps and sync watchdog
`timescale 1ns/1ps
module transceiver_pin_function_mux #(
  parameter int SYNC_TIMEOUT = pin_mux_pkg::SYNC_TIMEOUT_CYC  // frame sync loss timeout in cycles
) (
  input  wire logic        clock,             // 100 MHz system clock
  input  wire logic        reset,             // synchronous reset, active high
  input  wire logic        lowSupply,         // supply monitor flag, active high
  // apb slave
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb enable
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  // strap a (dedicated) and strap b / gpio 2 / aux clock pin
  input  wire logic        addrStrapA,        // first address strap level
  input  wire logic        addrStrapBIn,      // addr_strap_b_gpio pin input
  output logic             addrStrapBOut,     // addr_strap_b_gpio pin output
  output logic             addrStrapBOe_n,    // addr_strap_b_gpio enable, low drives
  output logic      [1:0]  targetAddress,     // control-bus target address
  // bit clock pin
  input  wire logic        bitClockIn,        // bit clock pin input
  output logic             bitClockOut,       // bit clock pin output
  output logic             bitClockOe_n,      // bit clock enable, low drives
  input  wire logic        localBitClock,     // subordinate bit clock from core
  output logic             bitClockToCore,    // main node bit clock to core
  // frame sync pin
  input  wire logic        frameSyncIn,       // frame sync pin input
  output logic             frameSyncOut,      // frame sync pin output
  output logic             frameSyncOe_n,     // frame sync enable, low drives
  input  wire logic        localFrameSync,    // subordinate frame sync from core
  output logic             frameSyncToCore,   // main node frame sync to core
  output logic             busResetReq,       // level: frame sync lost, bus reset
  // serial_tx_a_pin
  input  wire logic        txAPinIn,          // serial_tx_a_pin input
  output logic             txAPinOut,         // serial_tx_a_pin output
  output logic             txAPinOe_n,        // serial_tx_a_pin enable, low drives
  input  wire logic        serialTxA,         // serial_tx_a data from core
  // serial_tx_b_pin
  input  wire logic        txBPinIn,          // serial_tx_b_pin input
  output logic             txBPinOut,         // serial_tx_b_pin output
  output logic             txBPinOe_n,        // serial_tx_b_pin enable, low drives
  input  wire logic        serialTxB,         // serial_tx_b data from core
  output logic             serialRxB,         // serial_rx_b data to core (relocated)
  // serial_rx_a_pin
  input  wire logic        rxAPinIn,          // serial_rx_a_pin input
  output logic             rxAPinOut,         // serial_rx_a_pin output
  output logic             rxAPinOe_n,        // serial_rx_a_pin enable, low drives
  output logic             serialRxA,         // serial_rx_a data to core
  output logic             micInputA,         // mic_input_a data to core
  output logic             micClockOut        // mic_clock_out for the dedicated pin
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] mode;
  logic [31:0] pinSel;
  logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioOut;
  logic [pin_mux_pkg::GPIO_COUNT-1:0] gpioOe;
  logic [15:0] clkDiv;
  logic        strapCaught;
  logic        inReset;
  logic        syncLostSticky;
  logic        lowSupplySticky;

  // apb decode
  wire apbWrite  = psel && penable && pwrite;
  wire hitMode   = (paddr == pin_mux_pkg::ADDR_MODE);
  wire hitPinSel = (paddr == pin_mux_pkg::ADDR_PINSEL);
  wire hitOut    = (paddr == pin_mux_pkg::ADDR_GPIO_OUT);
  wire hitOe     = (paddr == pin_mux_pkg::ADDR_GPIO_OE);
  wire hitIn     = (paddr == pin_mux_pkg::ADDR_GPIO_IN);
  wire hitStat   = (paddr == pin_mux_pkg::ADDR_STATUS);
  wire hitDiv    = (paddr == pin_mux_pkg::ADDR_CLKDIV);
  wire hitAny    = hitMode | hitPinSel | hitOut | hitOe | hitIn | hitStat | hitDiv;

  // role and function selects
  wire subNode    = mode[pin_mux_pkg::MODE_SUBNODE_BIT];
  wire selAuxClk  = pinSel[pin_mux_pkg::SEL_AUXCLK_B_BIT];
  wire selTxA     = pinSel[pin_mux_pkg::SEL_TX_A_BIT];
  wire selTxB     = pinSel[pin_mux_pkg::SEL_TX_B_BIT];
  wire selRxBAlt  = pinSel[pin_mux_pkg::SEL_RX_B_ALT_BIT];
  wire selRxA     = pinSel[pin_mux_pkg::SEL_RX_A_BIT];
  wire selMicA    = pinSel[pin_mux_pkg::SEL_MIC_A_BIT];
  wire selMicBclk = pinSel[pin_mux_pkg::SEL_MIC_ON_BCLK_BIT];

  // watchdog loss and supply faults
  wire syncLost;
  wire faultReset = syncLost || lowSupply;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog only runs where frame sync is an input (main node)

  sync_watchdog #(
    .TIMEOUT (SYNC_TIMEOUT)
  ) u_watchdog (
    .clock    (clock),
    .reset    (reset),
    .enable   (!subNode && !inReset),
    .syncIn   (frameSyncIn),
    .syncLost (syncLost)
  );

  // one divider shared by the aux clock and the microphone clock
  wire divClock;
  wire divRun = selAuxClk || selMicA;

  clock_divider #(
    .WIDTH (16)
  ) u_divider (
    .clock  (clock),
    .reset  (reset),
    .run    (divRun),
    .half   (clkDiv),
    .clkOut (divClock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset tracking and strap capture one edge after release

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      inReset       <= 1'b1;
      strapCaught   <= 1'b0;
      targetAddress <= 2'h0;
    end
    else
    begin
      inReset <= 1'b0;
      if (!strapCaught)
      begin
        targetAddress <= {addrStrapBIn, addrStrapA};
        strapCaught   <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; faults clear pin configuration back to inputs

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mode    <= pin_mux_pkg::MODE_RESET;
      pinSel  <= pin_mux_pkg::PINSEL_RESET;
      gpioOut <= '0;
      gpioOe  <= '0;
      clkDiv  <= pin_mux_pkg::CLKDIV_RESET;
    end
    else if (faultReset)
    begin
      pinSel <= pin_mux_pkg::PINSEL_RESET;
      gpioOe <= '0;
    end
    else if (apbWrite)
    begin
      if (hitMode)
        mode <= pwdata;
      if (hitPinSel)
        pinSel <= pwdata;
      if (hitOut)
        gpioOut <= pwdata[pin_mux_pkg::GPIO_COUNT-1:0];
      if (hitOe)
        gpioOe <= pwdata[pin_mux_pkg::GPIO_COUNT-1:0];
      if (hitDiv)
        clkDiv <= pwdata[15:0];
    end
  end

  // sticky fault flags: set wins over a write-one clear
  wire clearStat = apbWrite && hitStat;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      syncLostSticky  <= 1'b0;
      lowSupplySticky <= 1'b0;
    end
    else
    begin
      syncLostSticky  <= syncLost ||
                         (syncLostSticky && !(clearStat && pwdata[pin_mux_pkg::STAT_SYNC_LOST]));
      lowSupplySticky <= lowSupply ||
                         (lowSupplySticky && !(clearStat && pwdata[pin_mux_pkg::STAT_LOW_SUPPLY]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path; one-cycle access, unmapped addresses error

  wire [pin_mux_pkg::GPIO_COUNT-1:0] gpioIn;
  wire [31:0] statusWord;

  assign statusWord = {27'h0, lowSupplySticky, syncLostSticky, !syncLost, targetAddress};

  wire [31:0] readMux =
      hitMode   ? mode :
      hitPinSel ? pinSel :
      hitOut    ? {28'h0, gpioOut} :
      hitOe     ? {28'h0, gpioOe} :
      hitIn     ? {28'h0, gpioIn} :
      hitStat   ? statusWord :
      hitDiv    ? {16'h0, clkDiv} :
                  32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hitAny;

  always_ff @(posedge clock)
  begin
    if (reset)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= readMux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin drive decisions; dedicated function beats gpio, all off in reset

  // strap b pin: aux clock, else gpio 2, else high impedance
  wire strapBDrive = !inReset && (selAuxClk || gpioOe[pin_mux_pkg::GPIO_2_BIT]);
  assign addrStrapBOut  = selAuxClk ? divClock
                                    : gpioOut[pin_mux_pkg::GPIO_2_BIT];
  assign addrStrapBOe_n = !strapBDrive;

  // bit clock: driven only on a subordinate, optionally as mic clock
  wire bitClockDrive = !inReset && subNode;
  assign bitClockOut    = (selMicBclk && selMicA) ? divClock : localBitClock;
  assign bitClockOe_n   = !bitClockDrive;
  assign bitClockToCore = (!inReset && !subNode) ? bitClockIn : 1'b0;

  // frame sync: driven on a subordinate, received on the main node
  wire frameSyncDrive = !inReset && subNode;
  assign frameSyncOut    = localFrameSync;
  assign frameSyncOe_n   = !frameSyncDrive;
  assign frameSyncToCore = (!inReset && !subNode) ? frameSyncIn : 1'b0;
  assign busResetReq     = syncLost;

  // transmit a pin: serial data, else gpio 3
  wire txADrive = !inReset && (selTxA || gpioOe[pin_mux_pkg::GPIO_3_BIT]);
  assign txAPinOut  = selTxA ? serialTxA : gpioOut[pin_mux_pkg::GPIO_3_BIT];
  assign txAPinOe_n = !txADrive;

  // transmit b pin: serial data, else relocated receive input, else gpio 4
  wire txBIsGpio = !selTxB && !selRxBAlt;
  wire txBDrive  = !inReset && (selTxB || (txBIsGpio && gpioOe[pin_mux_pkg::GPIO_4_BIT]));
  assign txBPinOut  = selTxB ? serialTxB : gpioOut[pin_mux_pkg::GPIO_4_BIT];
  assign txBPinOe_n = !txBDrive;
  assign serialRxB  = (!inReset && !selTxB && selRxBAlt) ? txBPinIn : 1'b0;

  // receive a pin: microphone beats serial receive, else gpio 5
  wire rxAIsGpio = !selRxA && !selMicA;
  wire rxADrive  = !inReset && rxAIsGpio && gpioOe[pin_mux_pkg::GPIO_5_BIT];
  assign rxAPinOut  = gpioOut[pin_mux_pkg::GPIO_5_BIT];
  assign rxAPinOe_n = !rxADrive;
  assign micInputA  = (!inReset && selMicA) ? rxAPinIn : 1'b0;
  assign serialRxA  = (!inReset && !selMicA && selRxA) ? rxAPinIn : 1'b0;

  // dedicated mic clock pin runs whenever the microphone input is on
  assign micClockOut = selMicA ? divClock : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // gpio input readback; inputs read zero in reset or when not a gpio

  assign gpioIn[pin_mux_pkg::GPIO_2_BIT] = !inReset && !selAuxClk && addrStrapBIn;
  assign gpioIn[pin_mux_pkg::GPIO_3_BIT] = !inReset && !selTxA && txAPinIn;
  assign gpioIn[pin_mux_pkg::GPIO_4_BIT] = !inReset && txBIsGpio && txBPinIn;
  assign gpioIn[pin_mux_pkg::GPIO_5_BIT] = !inReset && rxAIsGpio && rxAPinIn;

endmodule : transceiver_pin_function_mux

// ---- design/pin_mux_pkg.sv ----
// package: register map, field layout and timing constants for the transceiver pin function mux
// Overview of operation
// - strap pins sampled at power-on reset set the control-bus target address
// - strap pin b is high impedance until software makes it a GPIO
// - strap pin b can be programmed as an auxiliary clock output
// - bit clock is input on the main node, driven output on a subordinate
// - subordinate using microphones may drive the mic clock on the bit clock pin
// - frame sync is input on the main node, output on a subordinate
// - frame sync delimits the serial data frames on transmit and receive pins
// - frame sync that stops toggling resets the bus after a delay
// - enabled serial transmit a drives outgoing serial data
// - transmit a pin disabled is GPIO, high impedance until configured
// - missing frame sync or low supply returns data and GPIO pins to high impedance
// - enabled serial transmit b drives outgoing serial data
// - transmit b pin may act as the second serial receive input
// - transmit b pin with both functions off is a GPIO
// - enabled serial receive a accepts incoming serial data
// - enabled microphone a makes receive a pin accept microphone data
// - receive a pin with serial and microphone off is a GPIO
// - during reset every pin is three-stated and every input disabled; the dedicated mic clock pin has no enable and is held low
package pin_mux_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_MODE      = 12'h000;
  localparam logic [11:0] ADDR_PINSEL    = 12'h004;
  localparam logic [11:0] ADDR_GPIO_OUT  = 12'h008;
  localparam logic [11:0] ADDR_GPIO_OE   = 12'h00C;
  localparam logic [11:0] ADDR_GPIO_IN   = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  localparam logic [11:0] ADDR_CLKDIV    = 12'h018;

  // mode register fields
  localparam int MODE_SUBNODE_BIT = 0;

  // pin selection register fields
  localparam int SEL_AUXCLK_B_BIT   = 0;
  localparam int SEL_TX_A_BIT       = 1;
  localparam int SEL_TX_B_BIT       = 2;
  localparam int SEL_RX_B_ALT_BIT   = 3;
  localparam int SEL_RX_A_BIT       = 4;
  localparam int SEL_MIC_A_BIT      = 5;
  localparam int SEL_MIC_ON_BCLK_BIT = 6;

  // gpio bit positions within the gpio registers
  localparam int GPIO_2_BIT = 0;
  localparam int GPIO_3_BIT = 1;
  localparam int GPIO_4_BIT = 2;
  localparam int GPIO_5_BIT = 3;
  localparam int GPIO_COUNT = 4;

  // status register fields
  localparam int STAT_ADDR_LSB   = 0;
  localparam int STAT_SYNC_OK    = 2;
  localparam int STAT_SYNC_LOST  = 3;
  localparam int STAT_LOW_SUPPLY = 4;

  // reset values
  localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
  localparam logic [31:0] PINSEL_RESET = 32'h0000_0000;
  localparam logic [15:0] CLKDIV_RESET = 16'h0004;

  // frame sync watchdog: time in microseconds, count in 100 MHz cycles
  localparam int CLOCK_MHZ        = 100;
  localparam int SYNC_TIMEOUT_US  = 100;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * CLOCK_MHZ;

endpackage : pin_mux_pkg

// ---- design/sync_watchdog.sv ----
// module: frame sync activity watchdog that flags a stalled frame sync
`timescale 1ns/1ps
module sync_watchdog #(
  parameter int TIMEOUT = pin_mux_pkg::SYNC_TIMEOUT_CYC  // cycles without an edge before loss
) (
  input  wire logic clock,     // system clock
  input  wire logic reset,     // synchronous reset, active high
  input  wire logic enable,    // watch only while frame sync is an input
  input  wire logic syncIn,    // sampled frame sync level
  output logic      syncLost   // level: no edge seen for TIMEOUT cycles
);

  localparam int CW = $clog2(TIMEOUT + 1);

  logic          lastSync;
  logic [CW-1:0] idleCount;
  wire           syncEdge = syncIn ^ lastSync;
  wire           expired  = (idleCount == CW'(TIMEOUT));

  ////////////////////////////////////////////////////////////////////////////
  // any edge restarts the count; loss stays until the next edge
  always_ff @(posedge clock)
  begin
    if (reset || !enable)
    begin
      lastSync  <= 1'b0;
      idleCount <= '0;
      syncLost  <= 1'b0;
    end
    else
    begin
      lastSync <= syncIn;
      if (syncEdge)
      begin
        idleCount <= '0;
        syncLost  <= 1'b0;
      end
      else if (expired)
        syncLost <= 1'b1;
      else
        idleCount <= idleCount + CW'(1);
    end
  end

endmodule : sync_watchdog

// ---- design/clock_divider.sv ----
// module: programmable divider producing the auxiliary and microphone clocks
`timescale 1ns/1ps
module clock_divider #(
  parameter int WIDTH = 16  // divider counter width
) (
  input  wire logic             clock,   // system clock
  input  wire logic             reset,   // synchronous reset, active high
  input  wire logic             run,     // divider runs only while high
  input  wire logic [WIDTH-1:0] half,    // half period in clock cycles, zero treated as one
  output logic                  clkOut   // divided clock, low while stopped
);

  logic [WIDTH-1:0] count;
  wire  [WIDTH-1:0] limit = (half == '0) ? WIDTH'(1) : half;

  ////////////////////////////////////////////////////////////////////////////
  // toggle every half period; stopping parks the output low
  always_ff @(posedge clock)
  begin
    if (reset || !run)
    begin
      count  <= '0;
      clkOut <= 1'b0;
    end
    else if (count >= limit - WIDTH'(1))
    begin
      count  <= '0;
      clkOut <= ~clkOut;
    end
    else
      count <= count + WIDTH'(1);
  end

endmodule : clock_divider

// ---- sim/far_side_model.sv ----
// model: host clocks and microphone data at the far side of the pins
`timescale 1ns/1ps
module far_side_model (
  input  wire logic clock,   // system clock
  input  wire logic syncRun, // frame sync toggles while high
  input  wire logic bcOe_n,  // device bit clock enable, low drives
  input  wire logic bcOut,   // device bit clock level
  input  wire logic fsOe_n,  // device frame sync enable, low drives
  input  wire logic fsOut,   // device frame sync level
  input  wire logic rxOe_n,  // device receive a enable, low drives
  input  wire logic rxOut,   // device receive a level
  output logic      bcPin,   // resolved bit clock wire
  output logic      fsPin,   // resolved frame sync wire
  output logic      rxPin    // resolved receive a wire
);
  logic       hostBc = 1'b0;
  logic       hostFs = 1'b0;
  logic [2:0] slot   = 3'h0;
  logic [7:0] shift  = 8'h5A;
  ////////////////////////////////////////////////////////////////
  // frame sync every eight cycles; stalls only when commanded
  always_ff @(posedge clock)
  begin
    hostBc <= ~hostBc;
    slot   <= slot + 3'h1;
    if (syncRun && slot == 3'h7)
      hostFs <= ~hostFs;
    shift <= {shift[6:0], shift[7] ^ shift[5] ^ shift[4] ^ shift[3]};
  end
  // a driving device wins the wire
  assign bcPin = (bcOe_n === 1'b0) ? bcOut : hostBc;
  assign fsPin = (fsOe_n === 1'b0) ? fsOut : hostFs;
  // fresh mic data every cycle
  assign rxPin = (rxOe_n === 1'b0) ? rxOut : shift[0];
endmodule : far_side_model

// ---- sim/transceiver_pin_function_mux_sva.sv ----
// checker: port level assertions for the pin mux
`timescale 1ns/1ps
module transceiver_pin_function_mux_sva #(
  parameter int SYNC_TIMEOUT = 20 // watchdog count of the bound design
) (
  input wire logic       clock, reset, lowSupply,   // clock, reset, supply flag
  input wire logic       addrStrapA, addrStrapBIn,  // strap levels
  input wire logic       addrStrapBOe_n,            // strap b enable
  input wire logic [1:0] targetAddress,             // captured address
  input wire logic       bitClockIn, bitClockOe_n,  // bit clock pin
  input wire logic       bitClockToCore,            // bit clock to core
  input wire logic       frameSyncIn, frameSyncOut, // frame sync pin
  input wire logic       frameSyncOe_n,             // frame sync enable
  input wire logic       localFrameSync,            // core frame sync
  input wire logic       frameSyncToCore,           // frame sync to core
  input wire logic       busResetReq,               // sync loss level
  input wire logic       txAPinOe_n, txBPinOe_n,    // transmit enables
  input wire logic       rxAPinOe_n,                // receive a enable
  input wire logic       serialRxA, serialRxB,      // serial data to core
  input wire logic       micInputA                  // mic data to core
);
  localparam int QLO = SYNC_TIMEOUT - 1;
  localparam int QHI = SYNC_TIMEOUT + 4;
  int   quiet;
  logic fsLast;
  logic dataHiz;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // quiet frame sync cycles; slack for enable lag
  always_ff @(posedge clock)
  begin
    fsLast <= frameSyncIn;
    quiet  <= (reset || !frameSyncOe_n || frameSyncIn != fsLast) ? 0 : quiet + 1;
  end
  assign dataHiz = txAPinOe_n & txBPinOe_n & rxAPinOe_n & addrStrapBOe_n;
  sequence s_syncEdge; busResetReq ##0 $changed(frameSyncIn); endsequence
  sequence s_released; $past(reset, 2) && !$past(reset); endsequence
  property p_release_hiz; $past(reset) |-> dataHiz && bitClockOe_n && frameSyncOe_n && !bitClockToCore
    && !frameSyncToCore && !serialRxA && !serialRxB && !micInputA; endproperty
  property p_strap; s_released |-> targetAddress == {$past(addrStrapBIn), $past(addrStrapA)}; endproperty
  property p_strap_hold; !$past(reset, 2) && !$past(reset) |-> $stable(targetAddress); endproperty
  property p_main_in; frameSyncOe_n && !$past(reset) |-> bitClockOe_n && bitClockToCore == bitClockIn
    && frameSyncToCore == frameSyncIn; endproperty
  property p_sub_out; !frameSyncOe_n |-> !bitClockOe_n && frameSyncOut == localFrameSync
    && !frameSyncToCore; endproperty
  property p_wdog_rise; $rose(busResetReq) |-> quiet >= QLO && quiet <= QHI; endproperty
  property p_wdog_late; frameSyncOe_n && quiet > QHI |-> busResetReq; endproperty
  property p_wdog_clear; s_syncEdge |-> ##[1:4] !busResetReq; endproperty
  property p_fault_hiz; $past(busResetReq, 2) && $past(busResetReq) |-> dataHiz; endproperty
  property p_low_hiz; $past(lowSupply, 2) && $past(lowSupply) |-> dataHiz; endproperty
  a_release_hiz: assert property (p_release_hiz) else $error("pins not idle after reset");
  a_strap: assert property (p_strap) else $error("strap address not captured");
  a_strap_hold: assert property (p_strap_hold) else $error("address moved");
  a_main_in: assert property (p_main_in) else $error("main node inputs wrong");
  a_sub_out: assert property (p_sub_out) else $error("subordinate outputs wrong");
  a_wdog_rise: assert property (p_wdog_rise) else $error("sync loss timing off");
  a_wdog_late: assert property (p_wdog_late) else $error("sync loss missed");
  a_wdog_clear: assert property (p_wdog_clear) else $error("sync loss not cleared");
  a_fault_hiz: assert property (p_fault_hiz) else $error("pins driven after sync loss");
  a_low_hiz: assert property (p_low_hiz) else $error("pins driven in low supply");
endmodule : transceiver_pin_function_mux_sva

bind transceiver_pin_function_mux transceiver_pin_function_mux_sva #(.SYNC_TIMEOUT(SYNC_TIMEOUT)) u_sva (.*);

// ---- sim/transceiver_pin_function_mux_tb.sv ----
// testbench: random and corner checks of the pin mux
`timescale 1ns/1ps
module transceiver_pin_function_mux_tb;
  localparam int SYNC = 20;
  logic        clock = 1'b0, reset = 1'b1, lowSupply = 1'b0, syncRun = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, lastErr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h9F39;
  logic        addrStrapA = 1'b1, sbDrv = 1'b0, txBDrv = 1'b1, addrStrapBIn, addrStrapBOut, addrStrapBOe_n;
  logic [1:0]  targetAddress;
  logic        bitClockIn, bitClockOut, bitClockOe_n, localBitClock = 1'b0, bitClockToCore;
  logic        frameSyncIn, frameSyncOut, frameSyncOe_n, localFrameSync = 1'b0, frameSyncToCore;
  logic        busResetReq, txAPinIn, txAPinOut, txAPinOe_n, serialTxA = 1'b0;
  logic        txBPinIn, txBPinOut, txBPinOe_n, serialTxB = 1'b0, serialRxB;
  logic        rxAPinIn, rxAPinOut, rxAPinOe_n, serialRxA, micInputA, micClockOut;
  logic [6:0]  sel;
  logic [3:0]  gOe, gOut, oe;
  logic        mode;
  int          fail_count = 0, comparisons = 0, cycles = 0, n;
  ////////////////////////////////////////////////////////////////
  // released wires show bench values
  assign addrStrapBIn = (addrStrapBOe_n === 1'b0) ? addrStrapBOut : sbDrv;
  assign txAPinIn     = (txAPinOe_n === 1'b0) ? txAPinOut : ~txAPinOut;
  assign txBPinIn     = (txBPinOe_n === 1'b0) ? txBPinOut : txBDrv;
  wire   [3:0]  oeAll = {addrStrapBOe_n, txAPinOe_n, txBPinOe_n, rxAPinOe_n};
  transceiver_pin_function_mux #(.SYNC_TIMEOUT(SYNC)) u_transceiver_pin_function_mux (.*);
  far_side_model u_far_side_model (.clock, .syncRun, .bcOe_n(bitClockOe_n), .bcOut(bitClockOut),
    .fsOe_n(frameSyncOe_n), .fsOut(frameSyncOut), .rxOe_n(rxAPinOe_n), .rxOut(rxAPinOut),
    .bcPin(bitClockIn), .fsPin(frameSyncIn), .rxPin(rxAPinIn));
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // expected enables {strap b, tx a, tx b, rx a}: dedicated beats gpio
  function automatic logic [3:0] want_oe(input logic [6:0] s, input logic [3:0] e);
    return {~(s[0] | e[0]), ~(s[1] | e[1]), ~(s[2] | (~s[3] & e[2])), ~(~s[4] & ~s[5] & e[3])};
  endfunction : want_oe
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic set_pins(input logic [6:0] s, input logic [3:0] e);
    apb(1'b1, pin_mux_pkg::ADDR_PINSEL, {25'h0, s});
    apb(1'b1, pin_mux_pkg::ADDR_GPIO_OE, {28'h0, e});
  endtask : set_pins
  ////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end
  initial
  begin
    tick(6);
    reset <= 1'b0;
    tick(3);
    check(targetAddress, {sbDrv, addrStrapA});
    apb(1'b0, pin_mux_pkg::ADDR_STATUS, 32'h0);
    check(rd[1:0], {sbDrv, addrStrapA});
    apb(1'b0, pin_mux_pkg::ADDR_PINSEL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    check({lastErr, oeAll}, 5'h1F);
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      {mode, gOut, gOe, sel} = seed[15:0];
      if (i == 0) {gOe, sel} = 11'h0;
      if (i == 1) sel = 7'h7F;
      {serialTxA, serialTxB, txBDrv, sbDrv, localBitClock, localFrameSync} <= seed[21:16];
      apb(1'b1, pin_mux_pkg::ADDR_MODE, {31'h0, mode});
      apb(1'b1, pin_mux_pkg::ADDR_GPIO_OUT, {28'h0, gOut});
      set_pins(sel, gOe);
      tick(2);
      oe = want_oe(sel, gOe);
      check(oeAll, oe);
      if (!oe[3] && !sel[0]) check(addrStrapBOut, gOut[0]);
      if (!oe[2]) check(txAPinOut, sel[1] ? serialTxA : gOut[1]);
      if (!oe[1]) check(txBPinOut, sel[2] ? serialTxB : gOut[2]);
      if (!sel[2] && sel[3]) check(serialRxB, txBDrv);
      if (!oe[0]) check(rxAPinOut, gOut[3]);
      if (sel[5]) check(micInputA, rxAPinIn);
      else if (sel[4]) check(serialRxA, rxAPinIn);
      check({bitClockOe_n, frameSyncOe_n}, {2{~mode}});
      if (mode) check(bitClockOut, (sel[6] && sel[5]) ? micClockOut : localBitClock);
      apb(1'b0, pin_mux_pkg::ADDR_GPIO_IN, 32'h0);
      check(rd[2:0], {~sel[2] & ~sel[3] & (oe[1] ? txBDrv : gOut[2]), ~sel[1] & (gOut[1] ^ oe[2]),
        ~sel[0] & (oe[3] ? sbDrv : gOut[0])});
    end
    apb(1'b1, pin_mux_pkg::ADDR_MODE, 32'h0);
    set_pins(7'h16, 4'hF);
    syncRun <= 1'b0;
    for (n = 0; busResetReq !== 1'b1 && n < SYNC + 40; n++) tick(1);
    tick(2);
    check({busResetReq, oeAll}, 5'h1F);
    apb(1'b0, pin_mux_pkg::ADDR_PINSEL, 32'h0);
    check(rd, 32'h0);
    syncRun <= 1'b1;
    for (n = 0; busResetReq !== 1'b0 && n < 30; n++) tick(1);
    apb(1'b1, pin_mux_pkg::ADDR_STATUS, 32'h8);
    apb(1'b0, pin_mux_pkg::ADDR_STATUS, 32'h0);
    check({busResetReq, rd[3]}, 2'b00);
    apb(1'b1, pin_mux_pkg::ADDR_MODE, 32'h1);
    set_pins(7'h16, 4'hF);
    lowSupply <= 1'b1;
    tick(3);
    set_pins(7'h16, 4'hF);
    check({frameSyncOe_n, oeAll}, 5'h0F);
    lowSupply <= 1'b0;
    apb(1'b0, pin_mux_pkg::ADDR_STATUS, 32'h0);
    check(rd[4], 1'b1);
    set_pins(7'h16, 4'hF);
    reset <= 1'b1;
    tick(2);
    check({bitClockToCore, frameSyncToCore, oeAll}, 6'h0F);
    reset <= 1'b0;
    tick(2);
    apb(1'b0, pin_mux_pkg::ADDR_PINSEL, 32'h0);
    check(rd, 32'h0);
    close_out();
  end
endmodule : transceiver_pin_function_mux_tb
